// >>> hdl/sac_access_ctrl.sv
`timescale 1ns/10ps
module sac_access_ctrl
#(
  parameter int unsigned OSC_DIV     = sac_pkg::OSC_DIV_CYC,
  parameter int unsigned WRITE_TICKS = sac_pkg::WRITE_OSC_TICKS
)
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [5:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  input  wire logic       global_irq_enable,
  output logic      [7:0] io_rdata,
  output logic            ready_irq,
  output logic            cpu_stall
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  sac_store_if sif ();

  logic [8:0] store_address;
  logic [7:0] store_data;
  logic       ready_irq_enable;
  logic       master_write_enable;
  logic       write_strobe;
  logic [2:0] mwe_cnt;
  logic [2:0] stall_cnt;
  logic [2:0] next_stall_cnt;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire sel_high = io_wr && (io_addr == sac_pkg::ADDR_HIGH_OFS);
  wire sel_low  = io_wr && (io_addr == sac_pkg::ADDR_LOW_OFS);
  wire sel_data = io_wr && (io_addr == sac_pkg::DATA_OFS);
  wire sel_ctrl = io_wr && (io_addr == sac_pkg::CTRL_OFS);

  wire mwe_set     = sel_ctrl && io_wdata[sac_pkg::MWE_BIT];
  wire strobe_req  = sel_ctrl && io_wdata[sac_pkg::WS_BIT];
  wire start_write = strobe_req && master_write_enable && !write_strobe;
  wire read_req    = sel_ctrl && io_wdata[sac_pkg::RS_BIT];
  wire start_read  = read_req && !write_strobe && !start_write;
  wire addr_open   = !write_strobe && !start_write;

  wire [7:0] ctrl_view = {4'h0, ready_irq_enable, master_write_enable,
                          write_strobe, 1'b0};
  wire [7:0] high_view = {7'h00, store_address[8]};

  wire [7:0] rd_mux = (io_addr == sac_pkg::ADDR_HIGH_OFS) ? high_view :
                      (io_addr == sac_pkg::ADDR_LOW_OFS)  ? store_address[7:0] :
                      (io_addr == sac_pkg::DATA_OFS)      ? store_data :
                      (io_addr == sac_pkg::CTRL_OFS)      ? ctrl_view :
                                                            8'h00;

  assign next_stall_cnt = start_read  ? sac_pkg::RD_STALL_CYC :
                          start_write ? sac_pkg::WR_STALL_CYC :
                          (stall_cnt != 3'h0) ? stall_cnt - 3'h1 : 3'h0;

  assign sif.start   = start_write;
  assign sif.wr_addr = store_address;
  assign sif.wr_data = store_data;
  assign sif.rd_addr = store_address;

  // ----------------------------------------
  // Store timing and memory
  // ----------------------------------------
  sac_store_core
  #(
    .OSC_DIV     (OSC_DIV),
    .WRITE_TICKS (WRITE_TICKS)
  )
  u_core
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .sif     (sif.store)
  );

  // ----------------------------------------
  // Address and data registers
  // ----------------------------------------
  // Address left unreset on purpose; software must load it
  always_ff @(posedge clk_sys)
  begin
    if (sel_high && addr_open)
      store_address[8] <= io_wdata[0];
    if (sel_low && addr_open)
      store_address[7:0] <= io_wdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      store_data <= sac_pkg::RDATA_RST;
    else if (start_read)
      store_data <= sif.rd_data;
    else if (sel_data)
      store_data <= io_wdata;
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ready_irq_enable <= 1'b0;
    else if (sel_ctrl)
      ready_irq_enable <= io_wdata[sac_pkg::RIE_BIT];
  end

  // Rewriting the enable restarts its window
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      master_write_enable <= 1'b0;
      mwe_cnt             <= 3'h0;
    end
    else if (mwe_set)
    begin
      master_write_enable <= 1'b1;
      mwe_cnt             <= sac_pkg::MWE_WINDOW_CYC;
    end
    else if (mwe_cnt == 3'h1)
    begin
      master_write_enable <= 1'b0;
      mwe_cnt             <= 3'h0;
    end
    else if (mwe_cnt != 3'h0)
      mwe_cnt <= mwe_cnt - 3'h1;
  end

  // Software can only set the strobe; hardware alone clears it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      write_strobe <= 1'b0;
    else if (start_write)
      write_strobe <= 1'b1;
    else if (sif.done)
      write_strobe <= 1'b0;
  end

  // ----------------------------------------
  // Core side outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      stall_cnt <= 3'h0;
      cpu_stall <= 1'b0;
    end
    else
    begin
      stall_cnt <= next_stall_cnt;
      cpu_stall <= (next_stall_cnt != 3'h0);
    end
  end

  // Level request, no flag to clear
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ready_irq <= 1'b0;
    else
      ready_irq <= ready_irq_enable && global_irq_enable && !write_strobe;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      io_rdata <= sac_pkg::RDATA_RST;
    else if (io_rd)
      io_rdata <= rd_mux;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_mwe_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(master_write_enable) |-> master_write_enable[*4];
  endproperty
  a_mwe_hold: assert property (p_mwe_hold)
    else $error("master enable dropped inside its window");

  property p_mwe_clear;
    @(posedge clk_sys) disable iff (sys_rst)
      mwe_set ##1 !mwe_set [*4] |=> !master_write_enable;
  endproperty
  a_mwe_clear: assert property (p_mwe_clear)
    else $error("master enable not cleared after four cycles");

  property p_ignore_strobe;
    @(posedge clk_sys) disable iff (sys_rst)
      strobe_req && !master_write_enable && !write_strobe |=> !write_strobe;
  endproperty
  a_ignore_strobe: assert property (p_ignore_strobe)
    else $error("strobe without master enable started a write");

  property p_start_write;
    @(posedge clk_sys) disable iff (sys_rst)
      strobe_req && master_write_enable && !write_strobe |=> write_strobe && sif.busy;
  endproperty
  a_start_write: assert property (p_start_write)
    else $error("guarded strobe did not start a write");

  property p_wr_stall;
    @(posedge clk_sys) disable iff (sys_rst)
      start_write ##1 !start_read [*2] |-> $past(cpu_stall) && cpu_stall ##1 !cpu_stall;
  endproperty
  a_wr_stall: assert property (p_wr_stall)
    else $error("write stall is not two cycles");

  property p_rd_stall;
    @(posedge clk_sys) disable iff (sys_rst)
      start_read ##1 (!start_read && !start_write) [*4] |->
        $past(cpu_stall, 3) && cpu_stall ##1 !cpu_stall;
  endproperty
  a_rd_stall: assert property (p_rd_stall)
    else $error("read stall is not four cycles");

  property p_rd_data;
    @(posedge clk_sys) disable iff (sys_rst)
      start_read |=> store_data == $past(sif.rd_data);
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("read strobe did not load the data register");

  property p_busy_blocks;
    @(posedge clk_sys) disable iff (sys_rst)
      write_strobe && (sel_low || sel_high || read_req) |=>
        $stable(store_address) && !(cpu_stall && stall_cnt == sac_pkg::RD_STALL_CYC);
  endproperty
  a_busy_blocks: assert property (p_busy_blocks)
    else $error("access accepted during a write");

  property p_irq_level;
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(write_strobe) && ready_irq_enable && global_irq_enable |=> ready_irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("ready request missing after write end");

  property p_irq_gate;
    @(posedge clk_sys) disable iff (sys_rst)
      !global_irq_enable || !ready_irq_enable || write_strobe |=> !ready_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("ready request not gated");

  property p_strobe_clear;
    @(posedge clk_sys) disable iff (sys_rst)
      sif.done |=> !write_strobe;
  endproperty
  a_strobe_clear: assert property (p_strobe_clear)
    else $error("write strobe stuck after completion");

  property p_ctrl_view;
    @(posedge clk_sys) disable iff (sys_rst)
      io_rd && io_addr == sac_pkg::CTRL_OFS |=> io_rdata[7:4] == 4'h0 && !io_rdata[0];
  endproperty
  a_ctrl_view: assert property (p_ctrl_view)
    else $error("reserved control bits not zero");

  c_write: cover property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(write_strobe));
  c_read: cover property (@(posedge clk_sys) disable iff (sys_rst) start_read);
  c_ignored: cover property (@(posedge clk_sys) disable iff (sys_rst)
    strobe_req && !master_write_enable);
  c_irq: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(ready_irq));
endmodule

// >>> inc/sac_pkg.sv
// Functional notes
// - Store holds 512 separately readable and writable bytes.
// - Address is linear 9 bits; bit 8 in high byte, bits 7..0 low.
// - Address bits 15..9 read zero and ignore writes.
// - Address has no reset value; software loads it before any access.
// - Write trigger programs the data register byte at the held address.
// - Read trigger loads the data register from the held address.
// - Control bits 7..4 read zero.
// - Bit 3 enables ready request, gated by global interrupt enable.
// - Ready request is a level while write strobe is zero, no flag.
// - Bit 2 master enable; strobe within four cycles starts programming.
// - Strobe with master enable zero is ignored.
// - Master enable clears itself four cycles after being set.
// - A store read stalls the core four cycles.
// - Starting a store write stalls the core two cycles.
// - Writes are self-timed; status shows completion.
// - Bit 1 write strobe stays set while programming, clears when done.
// - Bit 0 read strobe delivers the byte at once.
// - During a write, reads and address changes are refused.
// - Write time is 8448 ticks of a 1 MHz timing oscillator.
package sac_pkg;

  // ----------------------------------------
  // I/O register offsets
  // ----------------------------------------
  localparam logic [5:0] ADDR_HIGH_OFS = 6'h03;
  localparam logic [5:0] ADDR_LOW_OFS  = 6'h02;
  localparam logic [5:0] DATA_OFS      = 6'h01;
  localparam logic [5:0] CTRL_OFS      = 6'h00;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int unsigned RIE_BIT = 3;
  localparam int unsigned MWE_BIT = 2;
  localparam int unsigned WS_BIT  = 1;
  localparam int unsigned RS_BIT  = 0;

  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int unsigned STORE_BYTES = 512;
  localparam int unsigned ADDR_W      = 9;
  localparam logic [7:0]  RDATA_RST   = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned OSC_PERIOD_NS   = 1000;
  localparam int unsigned OSC_DIV_CYC     = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned WRITE_OSC_TICKS = 8448;
  localparam logic [2:0]  MWE_WINDOW_CYC  = 3'h4;
  localparam logic [2:0]  RD_STALL_CYC    = 3'h4;
  localparam logic [2:0]  WR_STALL_CYC    = 3'h2;

endpackage

// >>> inc/sac_store_if.sv
`timescale 1ns/10ps
interface sac_store_if;
  logic       start;
  logic [8:0] wr_addr;
  logic [7:0] wr_data;
  logic [8:0] rd_addr;
  logic [7:0] rd_data;
  logic       busy;
  logic       done;

  modport ctrl
  (
    output start,
    output wr_addr,
    output wr_data,
    output rd_addr,
    input  rd_data,
    input  busy,
    input  done
  );

  modport store
  (
    input  start,
    input  wr_addr,
    input  wr_data,
    input  rd_addr,
    output rd_data,
    output busy,
    output done
  );
endinterface

// >>> hdl/sac_store_core.sv
`timescale 1ns/10ps
module sac_store_core
#(
  parameter int unsigned OSC_DIV     = sac_pkg::OSC_DIV_CYC,
  parameter int unsigned WRITE_TICKS = sac_pkg::WRITE_OSC_TICKS
)
(
  input  wire logic  clk_sys,
  input  wire logic  sys_rst,
  sac_store_if.store sif
);
  localparam int unsigned DIV_W  = $clog2(OSC_DIV + 1);
  localparam int unsigned TICK_W = $clog2(WRITE_TICKS + 1);

  if (OSC_DIV < 2 || WRITE_TICKS < 1)
  begin : g_chk
    $error("sac_store_core: divider or write length out of range");
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // No reset: contents are nonvolatile
  logic [7:0]        mem [sac_pkg::STORE_BYTES];
  logic [8:0]        pend_addr;
  logic [7:0]        pend_data;
  logic [DIV_W-1:0]  div_cnt;
  logic [TICK_W-1:0] tick_cnt;
  logic              busy_q;
  logic              done_q;

  wire osc_tick  = (div_cnt == DIV_W'(OSC_DIV - 1));
  wire last_tick = busy_q && osc_tick && (tick_cnt == TICK_W'(WRITE_TICKS - 1));

  assign sif.rd_data = mem[sif.rd_addr];
  assign sif.busy    = busy_q;
  assign sif.done    = done_q;

  // ----------------------------------------
  // Timing oscillator
  // ----------------------------------------
  // Free running, so the first tick of a write may come early by under 1 us
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || osc_tick)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + DIV_W'(1);
  end

  // ----------------------------------------
  // Self-timed write
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sif.start && !busy_q)
    begin
      pend_addr <= sif.wr_addr;
      pend_data <= sif.wr_data;
    end
    if (last_tick)
      mem[pend_addr] <= pend_data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      tick_cnt <= '0;
    end
    else
    begin
      done_q <= last_tick;
      if (sif.start && !busy_q)
      begin
        busy_q   <= 1'b1;
        tick_cnt <= '0;
      end
      else if (last_tick)
        busy_q <= 1'b0;
      else if (busy_q && osc_tick)
        tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_done_after_ticks;
    @(posedge clk_sys) disable iff (sys_rst)
      done_q |-> !busy_q && $past(busy_q) && $past(tick_cnt) == TICK_W'(WRITE_TICKS - 1);
  endproperty
  a_done_after_ticks: assert property (p_done_after_ticks)
    else $error("write finished at wrong tick count");
endmodule

// >>> sim/sac_core_model.sv
`timescale 1ns/10ps
module sac_core_model
(
  input  wire logic       clk_sys,
  output logic      [5:0] io_addr,
  output logic            io_wr,
  output logic            io_rd,
  output logic      [7:0] io_wdata,
  input  wire logic [7:0] io_rdata
);
  // ----
  // I/O access by the core, driven on the falling edge
  // ----
  initial
  begin
    io_addr  = 6'h00;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
  begin
    @(negedge clk_sys);
    io_addr  = a;
    io_wdata = v;
    io_wr    = 1'b1;
    @(negedge clk_sys);
    io_wr    = 1'b0;
    // Released bus never shows stale data
    io_wdata = ~v;
  end
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] v);
  begin
    @(negedge clk_sys);
    io_addr = a;
    io_rd   = 1'b1;
    @(negedge clk_sys);
    io_rd   = 1'b0;
    v       = io_rdata;
  end
  endtask

  // Gap above two idles lands the strobe outside the window
  task automatic guarded(input logic [7:0] keep, input int gap);
  begin
    wr(sac_pkg::CTRL_OFS, keep | 8'h04);
    idle(gap);
    wr(sac_pkg::CTRL_OFS, keep | 8'h06);
  end
  endtask
endmodule

// >>> sim/test_eeprom_access_controller.sv
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module test_eeprom_access_controller;
  logic       clk_sys           = 1'b0;
  logic       sys_rst;
  logic       global_irq_enable;
  logic [5:0] io_addr;
  logic       io_wr;
  logic       io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic       ready_irq;
  logic       cpu_stall;
  logic [7:0] d;
  logic [7:0] exp_mem [0:511];
  logic [8:0] adr [4]           = '{9'h000, 9'h0FF, 9'h100, 9'h1FF};
  int         miscompares       = 0;
  int         num_checks        = 0;
  int         n;

  always #2 clk_sys = ~clk_sys;

  // Short write time keeps the run brief
  sac_access_ctrl #(.OSC_DIV(2), .WRITE_TICKS(16)) dut
  (
    .clk_sys           (clk_sys),
    .sys_rst           (sys_rst),
    .io_addr           (io_addr),
    .io_wr             (io_wr),
    .io_rd             (io_rd),
    .io_wdata          (io_wdata),
    .global_irq_enable (global_irq_enable),
    .io_rdata          (io_rdata),
    .ready_irq         (ready_irq),
    .cpu_stall         (cpu_stall)
  );

  sac_core_model core
  (
    .clk_sys  (clk_sys),
    .io_addr  (io_addr),
    .io_wr    (io_wr),
    .io_rd    (io_rd),
    .io_wdata (io_wdata),
    .io_rdata (io_rdata)
  );

  // ----
  // Helpers
  // ----
  task automatic results;
  begin
    $display("Checks: %0d, miscompares: %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  task automatic rd_ctrl;
    core.rd(sac_pkg::CTRL_OFS, d);
  endtask

  task automatic count_stall;
  begin
    n = 0;
    repeat (8)
    begin
      if (cpu_stall === 1'b1)
        n++;
      @(negedge clk_sys);
    end
  end
  endtask

  task automatic wait_done;
    int i;
  begin
    for (i = 0; i < 100; i++)
    begin
      rd_ctrl();
      if (d[sac_pkg::WS_BIT] === 1'b0)
        break;
    end
    if (i == 100)
    begin
      miscompares++;
      results();
    end
  end
  endtask

  task automatic set_addr(input logic [8:0] a);
  begin
    core.wr(sac_pkg::ADDR_HIGH_OFS, {7'h00, a[8]});
    core.wr(sac_pkg::ADDR_LOW_OFS, a[7:0]);
  end
  endtask

  task automatic st_write(input logic [8:0] a, input logic [7:0] v, input int gap);
  begin
    set_addr(a);
    core.wr(sac_pkg::DATA_OFS, v);
    core.guarded(8'h08, gap);
    if (gap < 3)
      exp_mem[a] = v;
  end
  endtask

  task automatic st_read(input logic [8:0] a);
  begin
    set_addr(a);
    core.wr(sac_pkg::CTRL_OFS, 8'h01);
    count_stall();
    core.rd(sac_pkg::DATA_OFS, d);
  end
  endtask

  // ----
  // Sequence
  // ----
  initial
  begin
    sys_rst           = 1'b1;
    global_irq_enable = 1'b0;
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    `CHK({io_rdata, ready_irq, cpu_stall}, 10'h000)
    global_irq_enable = 1'b1;
    core.wr(sac_pkg::ADDR_HIGH_OFS, 8'hFF);
    core.rd(sac_pkg::ADDR_HIGH_OFS, d);
    `CHK(d, 8'h01)
    core.wr(sac_pkg::ADDR_LOW_OFS, 8'hA5);
    core.rd(sac_pkg::ADDR_LOW_OFS, d);
    `CHK(d, 8'hA5)
    foreach (adr[i])
    begin
      st_write(adr[i], 8'h3C ^ adr[i][7:0] ^ {7'h00, adr[i][8]}, 0);
      wait_done();
    end
    foreach (adr[i])
    begin
      st_read(adr[i]);
      `CHK(d, exp_mem[adr[i]])
      `CHK(n, 4)
    end
    core.wr(sac_pkg::CTRL_OFS, 8'hF8);
    rd_ctrl();
    `CHK(d, 8'h08)
    core.rd(6'h3F, d);
    `CHK(d, 8'h00)
    `CHK(ready_irq, 1'b1)
    global_irq_enable = 1'b0;
    core.idle(2);
    `CHK(ready_irq, 1'b0)
    global_irq_enable = 1'b1;
    core.wr(sac_pkg::CTRL_OFS, 8'h00);
    core.idle(2);
    `CHK(ready_irq, 1'b0)
    // Write in progress: stall, busy bit, refused accesses
    st_write(9'h0AA, 8'h5A, 0);
    count_stall();
    `CHK(n, 2)
    rd_ctrl();
    `CHK(d & 8'hFA, 8'h0A)
    `CHK(ready_irq, 1'b0)
    core.wr(sac_pkg::ADDR_LOW_OFS, 8'h00);
    core.wr(sac_pkg::CTRL_OFS, 8'h09);
    core.rd(sac_pkg::DATA_OFS, d);
    `CHK(d, 8'h5A)
    wait_done();
    core.rd(sac_pkg::ADDR_LOW_OFS, d);
    `CHK(d, 8'hAA)
    `CHK(ready_irq, 1'b1)
    st_read(9'h0AA);
    `CHK(d, 8'h5A)
    // Master enable window and timeout
    core.wr(sac_pkg::CTRL_OFS, 8'h04);
    rd_ctrl();
    `CHK(d, 8'h04)
    core.idle(4);
    rd_ctrl();
    `CHK(d, 8'h00)
    core.wr(sac_pkg::CTRL_OFS, 8'h02);
    rd_ctrl();
    `CHK(d, 8'h00)
    st_write(9'h1FF, 8'hE7, 3);
    core.idle(2);
    rd_ctrl();
    `CHK(d & 8'hFB, 8'h08)
    st_read(9'h1FF);
    `CHK(d, exp_mem[9'h1FF])
    st_write(9'h1FF, 8'hE7, 2);
    wait_done();
    st_read(9'h1FF);
    `CHK(d, 8'hE7)
    results();
  end
endmodule
